// ---- src/gpr_pin_sense.sv ----
`timescale 1ns/1ps
module gpr_pin_sense
  import gpr_pkg::*;
#(
  parameter bit IBOFF_OK = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_pad,
  input wire logic i_inv,
  input wire logic [2:0] i_sense,
  output logic o_level,
  output logic o_irq_hit,
  output logic o_event
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic event_r;
  logic ib_off;
  logic val;
  logic rise;
  logic fall;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= i_pad;
      sync2_r <= sync1_r;
    end
  end

  // RULE17 buffer disable where allowed
  assign ib_off = IBOFF_OK && (i_sense == GPR_SNS_IBOFF);
  // RULE7 RULE13 synced, inverted input
  assign val = ib_off ? 1'b0 : (sync2_r ^ i_inv);

  // RULE22 edges seen only after a clocked sample
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= val;
    end
  end

  assign rise = val & ~prev_r;
  assign fall = ~val & prev_r;
  assign o_level = val;

  // RULE15 sense mode selection
  always_comb begin
    unique case (i_sense)
      GPR_SNS_BOTH: o_irq_hit = rise | fall;
      GPR_SNS_RISE: o_irq_hit = rise;
      GPR_SNS_FALL: o_irq_hit = fall;
      GPR_SNS_LOW: o_irq_hit = ~val;
      default: o_irq_hit = 1'b0;
    endcase
  end

  // RULE23 RULE16 events on rising change, or high level
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      event_r <= 1'b0;
    end else if (i_sense == GPR_SNS_LOW) begin
      event_r <= val;
    end else if (ib_off || i_sense[2]) begin
      event_r <= 1'b0;
    end else begin
      event_r <= rise;
    end
  end
  assign o_event = event_r;
endmodule

// ---- src/gpr_pkg.sv ----
package gpr_pkg;
  localparam int GPR_NPIN = 8;
  localparam int GPR_AW = 6;
  // register offsets of the port
  localparam logic [5:0] GPR_OFS_DIR = 6'h00;
  localparam logic [5:0] GPR_OFS_DIR_SET = 6'h01;
  localparam logic [5:0] GPR_OFS_DIR_CLR = 6'h02;
  localparam logic [5:0] GPR_OFS_DIR_FLIP = 6'h03;
  localparam logic [5:0] GPR_OFS_OUT = 6'h04;
  localparam logic [5:0] GPR_OFS_OUT_SET = 6'h05;
  localparam logic [5:0] GPR_OFS_OUT_CLR = 6'h06;
  localparam logic [5:0] GPR_OFS_OUT_FLIP = 6'h07;
  localparam logic [5:0] GPR_OFS_IN = 6'h08;
  localparam logic [5:0] GPR_OFS_IRQPRI = 6'h09;
  localparam logic [5:0] GPR_OFS_IRQ0SEL = 6'h0A;
  localparam logic [5:0] GPR_OFS_IRQ1SEL = 6'h0B;
  localparam logic [5:0] GPR_OFS_PEND = 6'h0C;
  localparam logic [5:0] GPR_OFS_MPMASK = 6'h0D;
  localparam logic [5:0] GPR_OFS_SETUP0 = 6'h10;
  // virtual slot register index
  localparam logic [1:0] GPR_VREG_DIR = 2'h0;
  localparam logic [1:0] GPR_VREG_OUT = 2'h1;
  localparam logic [1:0] GPR_VREG_IN = 2'h2;
  localparam logic [1:0] GPR_VREG_PEND = 2'h3;
  // pad_setup fields
  localparam int GPR_INV_BIT = 6;
  localparam int GPR_DRV_LSB = 3;
  localparam int GPR_SNS_LSB = 0;
  localparam logic [6:0] GPR_SETUP_RST = 7'h00;
  localparam logic [7:0] GPR_REG_RST = 8'h00;
  localparam logic [3:0] GPR_IRQPRI_MASK = 4'hF;
  // sense codes
  localparam logic [2:0] GPR_SNS_BOTH = 3'h0;
  localparam logic [2:0] GPR_SNS_RISE = 3'h1;
  localparam logic [2:0] GPR_SNS_FALL = 3'h2;
  localparam logic [2:0] GPR_SNS_LOW = 3'h3;
  localparam logic [2:0] GPR_SNS_IBOFF = 3'h7;
  // drive and pull codes
  localparam logic [2:0] GPR_DRV_TOTEM = 3'h0;
  localparam logic [2:0] GPR_DRV_KEEP = 3'h1;
  localparam logic [2:0] GPR_DRV_PDN = 3'h2;
  localparam logic [2:0] GPR_DRV_PUP = 3'h3;
  localparam logic [2:0] GPR_DRV_WOR = 3'h4;
  localparam logic [2:0] GPR_DRV_WAND = 3'h5;
  localparam logic [2:0] GPR_DRV_WORPULL = 3'h6;
  localparam logic [2:0] GPR_DRV_WANDPULL = 3'h7;
  // highest port number that honours the buffer-disable code
  localparam int GPR_IBOFF_MAX_PORT = 5;
  localparam int GPR_EVT_PIN = 7;
endpackage

// ---- src/gpr_port.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - direction bit one drives, zero inputs
// RULE2 - set and clear strobes touch written ones
// RULE3 - flip strobe toggles; strobes read direction
// RULE4 - level bit drives pin when output
// RULE5 - level set/clear strobes touch written ones
// RULE6 - level flip toggles; strobes read level
// RULE7 - input register shows synced pin values
// RULE8 - nonzero priority field enables each interrupt
// RULE9 - irq0 select admits pins to interrupt 0
// RULE10 - irq1 select admits pins to interrupt 1
// RULE11 - sensed change on selected pin sets pending
// RULE12 - write one clears pending; upper reads zero
// RULE13 - polarity flip inverts in and out
// RULE14 - three bits choose drive and pull
// RULE15 - three bits choose sense mode
// RULE16 - low mode: high pin gives events continuously
// RULE17 - buffer disable only on ports A-F
// RULE18 - mask replicates next setup write
// RULE19 - mask self-clears after replicated write
// RULE20 - four virtual slots alias four registers
// RULE21 - event or clock routable to pin seven
// RULE22 - edge needs one clocked sample first
// RULE23 - events only on rising change outside low mode
// RULE24 - request when pending and priority nonzero
module gpr_port
  import gpr_pkg::*;
#(
  parameter int NPIN = GPR_NPIN,
  parameter logic [3:0] PORT_ID = 4'h0
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic [15:0] i_vp_map,
  input wire logic [3:0] i_vaddr,
  input wire logic i_vwr_en,
  input wire logic [7:0] i_vwr_data,
  input wire logic i_vrd_en,
  output logic [7:0] o_vrd_data,
  input wire logic [7:0] i_pad_in,
  output logic [7:0] o_pad_out,
  output logic [7:0] o_pad_oe,
  output logic [7:0] o_pad_pull_en,
  output logic [7:0] o_pad_pull_up,
  output logic [7:0] o_pad_keeper,
  input wire logic i_evt_ch0,
  input wire logic i_evt_route,
  input wire logic i_clk_route,
  output logic [7:0] o_pin_event,
  output logic [1:0] o_irq_req,
  output logic [3:0] o_irq_level
);
  localparam bit IBOFF_OK = (PORT_ID <= 4'(GPR_IBOFF_MAX_PORT));

  generate
    if (NPIN != 8) begin : g_chk
      $error("gpr_port supports exactly eight pins");
    end
  endgenerate

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  logic [7:0] dir_r;
  logic [7:0] out_r;
  logic [3:0] irqpri_r;
  logic [7:0] sel0_r;
  logic [7:0] sel1_r;
  logic [1:0] pend_r;
  logic [7:0] mpmask_r;
  logic [6:0] setup_r [NPIN];
  logic [7:0] level;
  logic [7:0] hit;
  logic [7:0] inv;
  logic vrd_hit;
  logic vwr_hit;
  logic wr;
  logic [5:0] waddr;
  logic [7:0] wdata;
  logic setup_wr;
  logic [1:0] pend_set;

  // RULE20 slot register index to real offset
  function automatic logic [5:0] vp_ofs(input logic [1:0] vreg);
    logic [5:0] o;
    o = GPR_OFS_DIR;
    unique case (vreg)
      GPR_VREG_DIR: o = GPR_OFS_DIR;
      GPR_VREG_OUT: o = GPR_OFS_OUT;
      GPR_VREG_IN: o = GPR_OFS_IN;
      GPR_VREG_PEND: o = GPR_OFS_PEND;
    endcase
    return o;
  endfunction

  function automatic logic vp_hit(input logic [15:0] map, input logic [1:0] slot);
    return map[4 * slot +: 4] == PORT_ID;
  endfunction

  // RULE3 RULE6 RULE12 read view of every offset
  function automatic logic [7:0] rd_mux(input logic [5:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a >= GPR_OFS_SETUP0 && a < GPR_OFS_SETUP0 + 6'(NPIN)) begin
      d = {1'b0, setup_r[3'(a - GPR_OFS_SETUP0)]};
    end else begin
      unique case (a)
        GPR_OFS_DIR, GPR_OFS_DIR_SET, GPR_OFS_DIR_CLR, GPR_OFS_DIR_FLIP: d = dir_r;
        GPR_OFS_OUT, GPR_OFS_OUT_SET, GPR_OFS_OUT_CLR, GPR_OFS_OUT_FLIP: d = out_r;
        GPR_OFS_IN: d = level;
        GPR_OFS_IRQPRI: d = {4'h0, irqpri_r};
        GPR_OFS_IRQ0SEL: d = sel0_r;
        GPR_OFS_IRQ1SEL: d = sel1_r;
        GPR_OFS_PEND: d = {6'h00, pend_r};
        GPR_OFS_MPMASK: d = mpmask_r;
        default: d = 8'h00;
      endcase
    end
    return d;
  endfunction

  // real bus write has priority over a virtual slot write in the same cycle; reads are served on both
  assign vwr_hit = i_vwr_en && !i_wr_en && vp_hit(i_vp_map, i_vaddr[3:2]);
  assign vrd_hit = i_vrd_en && vp_hit(i_vp_map, i_vaddr[3:2]);
  assign wr = i_wr_en || vwr_hit;
  assign waddr = i_wr_en ? i_addr : vp_ofs(i_vaddr[1:0]);
  assign wdata = i_wr_en ? i_wr_data : i_vwr_data;
  assign setup_wr = wr && waddr >= GPR_OFS_SETUP0 && waddr < GPR_OFS_SETUP0 + 6'(NPIN);

  // RULE1 RULE2 RULE3 direction and its strobes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_r <= GPR_REG_RST;
    end else if (wr) begin
      unique case (waddr)
        GPR_OFS_DIR: dir_r <= wdata;
        GPR_OFS_DIR_SET: dir_r <= dir_r | wdata;
        GPR_OFS_DIR_CLR: dir_r <= dir_r & ~wdata;
        GPR_OFS_DIR_FLIP: dir_r <= dir_r ^ wdata;
        default: dir_r <= dir_r;
      endcase
    end
  end

  // RULE4 RULE5 RULE6 level and its strobes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_r <= GPR_REG_RST;
    end else if (wr) begin
      unique case (waddr)
        GPR_OFS_OUT: out_r <= wdata;
        GPR_OFS_OUT_SET: out_r <= out_r | wdata;
        GPR_OFS_OUT_CLR: out_r <= out_r & ~wdata;
        GPR_OFS_OUT_FLIP: out_r <= out_r ^ wdata;
        default: out_r <= out_r;
      endcase
    end
  end

  // RULE8 RULE9 RULE10 interrupt setup registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irqpri_r <= 4'h0;
      sel0_r <= GPR_REG_RST;
      sel1_r <= GPR_REG_RST;
    end else if (wr) begin
      if (waddr == GPR_OFS_IRQPRI) begin
        irqpri_r <= wdata[3:0] & GPR_IRQPRI_MASK;
      end
      if (waddr == GPR_OFS_IRQ0SEL) begin
        sel0_r <= wdata;
      end
      if (waddr == GPR_OFS_IRQ1SEL) begin
        sel1_r <= wdata;
      end
    end
  end

  // RULE11 selected sensed pins set pending
  assign pend_set = {|(hit & sel1_r), |(hit & sel0_r)};

  // RULE12 write-one clears, a new set wins
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_r <= 2'b00;
    end else if (wr && waddr == GPR_OFS_PEND) begin
      pend_r <= (pend_r & ~wdata[1:0]) | pend_set;
    end else begin
      pend_r <= pend_r | pend_set;
    end
  end

  // RULE18 RULE19 multi-pin setup mask
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mpmask_r <= GPR_REG_RST;
    end else if (wr && waddr == GPR_OFS_MPMASK) begin
      mpmask_r <= wdata;
    end else if (setup_wr) begin
      mpmask_r <= GPR_REG_RST;
    end
  end

  // RULE13 RULE14 RULE15 RULE18 pin setup, replicated under mask
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NPIN; i++) begin
        setup_r[i] <= GPR_SETUP_RST;
      end
    end else if (setup_wr) begin
      for (int i = 0; i < NPIN; i++) begin
        if (mpmask_r != 8'h00 ? mpmask_r[i] : (waddr == GPR_OFS_SETUP0 + 6'(i))) begin
          setup_r[i] <= wdata[6:0];
        end
      end
    end
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
      o_vrd_data <= 8'h00;
    end else begin
      o_rd_data <= i_rd_en ? rd_mux(i_addr) : 8'h00;
      o_vrd_data <= vrd_hit ? rd_mux(vp_ofs(i_vaddr[1:0])) : 8'h00;
    end
  end

  genvar g;
  for (g = 0; g < NPIN; g++) begin : g_pin
    assign inv[g] = setup_r[g][GPR_INV_BIT];
    gpr_pin_sense #(
      .IBOFF_OK(IBOFF_OK)
    ) u_sense (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_pad(i_pad_in[g]),
      .i_inv(inv[g]),
      .i_sense(setup_r[g][GPR_SNS_LSB +: 3]),
      .o_level(level[g]),
      .o_irq_hit(hit[g]),
      .o_event(o_pin_event[g])
    );
  end

  // RULE1 RULE4 RULE13 RULE14 RULE21 pad drive and pull
  always_comb begin
    logic v;
    logic [2:0] drv;
    v = 1'b0;
    drv = 3'h0;
    for (int i = 0; i < NPIN; i++) begin
      drv = setup_r[i][GPR_DRV_LSB +: 3];
      v = out_r[i];
      if (i == GPR_EVT_PIN && i_clk_route) begin
        v = i_sys_clk;
      end else if (i == GPR_EVT_PIN && i_evt_route) begin
        v = i_evt_ch0;
      end
      v = v ^ inv[i];
      o_pad_out[i] = v;
      o_pad_oe[i] = dir_r[i];
      o_pad_pull_en[i] = 1'b0;
      o_pad_pull_up[i] = 1'b0;
      o_pad_keeper[i] = 1'b0;
      unique case (drv)
        GPR_DRV_TOTEM: o_pad_pull_en[i] = 1'b0;
        GPR_DRV_KEEP: o_pad_keeper[i] = 1'b1;
        GPR_DRV_PDN: o_pad_pull_en[i] = ~dir_r[i];
        GPR_DRV_PUP: begin
          o_pad_pull_en[i] = ~dir_r[i];
          o_pad_pull_up[i] = 1'b1;
        end
        GPR_DRV_WOR, GPR_DRV_WORPULL: begin
          o_pad_out[i] = 1'b1;
          o_pad_oe[i] = dir_r[i] & v;
          o_pad_pull_en[i] = drv[1];
        end
        GPR_DRV_WAND, GPR_DRV_WANDPULL: begin
          o_pad_out[i] = 1'b0;
          o_pad_oe[i] = dir_r[i] & ~v;
          o_pad_pull_en[i] = drv[1];
          o_pad_pull_up[i] = 1'b1;
        end
      endcase
    end
  end

  // RULE8 RULE24 requests to the interrupt controller
  assign o_irq_req = {pend_r[1] && irqpri_r[3:2] != 2'b00, pend_r[0] && irqpri_r[1:0] != 2'b00};
  assign o_irq_level = irqpri_r;

  AST_DIR_SET: assert property (i_wr_en && i_addr == GPR_OFS_DIR_SET |=> dir_r == ($past(dir_r) | $past(i_wr_data)))
    else $error("direction set strobe wrong"); // RULE2
  AST_DIR_CLR: assert property (i_wr_en && i_addr == GPR_OFS_DIR_CLR |=> dir_r == ($past(dir_r) & ~$past(i_wr_data)))
    else $error("direction clear strobe wrong"); // RULE2
  AST_DIR_FLIP: assert property (i_wr_en && i_addr == GPR_OFS_DIR_FLIP |=> dir_r == ($past(dir_r) ^ $past(i_wr_data)))
    else $error("direction flip strobe wrong"); // RULE3
  AST_OUT_FLIP: assert property (i_wr_en && i_addr == GPR_OFS_OUT_FLIP |=> out_r == ($past(out_r) ^ $past(i_wr_data)))
    else $error("level flip strobe wrong"); // RULE6
  AST_STROBE_RD: assert property (i_rd_en && i_addr == GPR_OFS_DIR_CLR && !wr |=> o_rd_data == $past(dir_r))
    else $error("direction strobe read wrong"); // RULE3
  AST_PEND_RD: assert property (i_rd_en && i_addr == GPR_OFS_PEND |=> o_rd_data[7:2] == 6'h00)
    else $error("pending upper bits not zero"); // RULE12
  AST_PEND_SET: assert property (pend_set[0] |=> pend_r[0])
    else $error("pending flag lost a set"); // RULE11
  AST_PEND_CLR: assert property (i_wr_en && i_addr == GPR_OFS_PEND && i_wr_data[1] && !pend_set[1] |=> !pend_r[1])
    else $error("pending flag not cleared"); // RULE12
  AST_MP_CLR: assert property (setup_wr && !(wr && waddr == GPR_OFS_MPMASK) |=> mpmask_r == 8'h00)
    else $error("setup mask not cleared"); // RULE19
  AST_IRQ_REQ: assert property (o_irq_req[1] == (pend_r[1] && irqpri_r[3:2] != 2'b00))
    else $error("interrupt request mismatch"); // RULE24
  AST_SETUP_RD: assert property (i_rd_en && i_addr == GPR_OFS_SETUP0 |=> !o_rd_data[7])
    else $error("setup top bit not zero"); // RULE13
endmodule

// ---- verif/gpr_pad_model.sv ----
`timescale 1ns/1ps
module gpr_pad_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pull_en,
  input wire logic [7:0] i_pull_up,
  input wire logic [7:0] i_keeper,
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext_val,
  output logic [7:0] o_pad
);
  logic [7:0] last_r;
  always_ff @(posedge i_sys_clk) begin
    last_r <= o_pad;
  end
  // an undriven pin without pull or keeper wanders every cycle
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_oe[i])
        o_pad[i] = i_out[i];
      else if (i_ext_en[i])
        o_pad[i] = i_ext_val[i];
      else if (i_pull_en[i])
        o_pad[i] = i_pull_up[i];
      else if (i_keeper[i])
        o_pad[i] = last_r[i];
      else
        o_pad[i] = ~last_r[i];
    end
  end
endmodule

// ---- verif/test_gpio_port_register_logic.sv ----
`timescale 1ns/1ps
module test_gpio_port_register_logic;
  import gpr_pkg::*;
  logic i_sys_clk, i_rst_n, i_wr_en, i_rd_en, i_vwr_en, i_vrd_en, i_evt_ch0, i_evt_route, i_clk_route;
  logic [5:0] i_addr;
  logic [3:0] i_vaddr;
  logic [7:0] i_wr_data, i_vwr_data, ext_en, ext_val, rd;
  logic [15:0] i_vp_map;
  wire [7:0] pad, o_rd_data, o_vrd_data, o_pad_out, o_pad_oe, pull_en, pull_up, keeper, o_pin_event;
  wire [1:0] o_irq_req;
  wire [3:0] o_irq_level;
  int failures = 0;
  int n_compared = 0;

  gpr_port dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_en(i_wr_en),
    .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_vp_map(i_vp_map),
    .i_vaddr(i_vaddr), .i_vwr_en(i_vwr_en), .i_vwr_data(i_vwr_data), .i_vrd_en(i_vrd_en),
    .o_vrd_data(o_vrd_data), .i_pad_in(pad), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
    .o_pad_pull_en(pull_en), .o_pad_pull_up(pull_up), .o_pad_keeper(keeper),
    .i_evt_ch0(i_evt_ch0), .i_evt_route(i_evt_route), .i_clk_route(i_clk_route),
    .o_pin_event(o_pin_event), .o_irq_req(o_irq_req), .o_irq_level(o_irq_level));

  gpr_pad_model pads (.i_sys_clk(i_sys_clk), .i_out(o_pad_out), .i_oe(o_pad_oe),
    .i_pull_en(pull_en), .i_pull_up(pull_up), .i_keeper(keeper), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_pad(pad));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one access, then an idle cycle so strobes never retrigger in one step
  task automatic bus(input bit v, input bit w, input logic [5:0] a, input logic [7:0] d);
    i_addr = a;
    i_vaddr = a[3:0];
    i_wr_data = d;
    i_vwr_data = d;
    i_wr_en = !v && w;
    i_rd_en = !v && !w;
    i_vwr_en = v && w;
    i_vrd_en = v && !w;
    @(posedge i_sys_clk);
    #1;
    {i_wr_en, i_rd_en, i_vwr_en, i_vrd_en} = 4'h0;
    rd = v ? o_vrd_data : o_rd_data;
    @(posedge i_sys_clk);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b0, 1'b1, a, d);
  endtask

  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, 1'b0, a, 8'h00);
    chk(rd, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  initial begin
    #200000;
    failures++;
    $display("FAIL t=%0t run did not finish", $time);
    give_verdict();
  end

  initial begin
    {i_wr_en, i_rd_en, i_vwr_en, i_vrd_en, i_evt_ch0, i_evt_route, i_clk_route} = 7'h00;
    i_addr = 6'h00;
    i_vaddr = 4'h0;
    i_wr_data = 8'h00;
    i_vwr_data = 8'h00;
    i_vp_map = 16'h0010;
    ext_en = 8'hFF;
    ext_val = 8'hA5;
    i_rst_n = 1'b0;
    cyc(3);
    i_rst_n = 1'b1;
    rc(GPR_OFS_DIR, 8'h00);
    chk(o_pad_oe, 8'h00);
    wr(GPR_OFS_DIR_SET, 8'h05);
    rc(GPR_OFS_DIR, 8'h05);
    wr(GPR_OFS_DIR_CLR, 8'h04);
    rc(GPR_OFS_DIR_CLR, 8'h01);
    wr(GPR_OFS_DIR_FLIP, 8'h0F);
    rc(GPR_OFS_DIR_SET, 8'h0E);
    chk(o_pad_oe, 8'h0E);
    wr(GPR_OFS_OUT_SET, 8'h0A);
    wr(GPR_OFS_OUT_CLR, 8'h02);
    rc(GPR_OFS_OUT_CLR, 8'h08);
    wr(GPR_OFS_OUT_FLIP, 8'h0C);
    rc(GPR_OFS_OUT_FLIP, 8'h04);
    chk(o_pad_out & o_pad_oe, 8'h04);
    wr(GPR_OFS_DIR, 8'h00);
    cyc(3);
    rc(GPR_OFS_IN, 8'hA5);
    wr(GPR_OFS_IN, 8'h00);
    rc(GPR_OFS_IN, 8'hA5);
    wr(GPR_OFS_SETUP0 + 6'h01, 8'h40);
    wr(GPR_OFS_SETUP0, 8'h07);
    cyc(3);
    rc(GPR_OFS_IN, 8'hA6);
    wr(GPR_OFS_SETUP0 + 6'h02, 8'hFF);
    rc(GPR_OFS_SETUP0 + 6'h02, 8'h7F);
    for (int c = 0; c < 8; c++) begin
      wr(GPR_OFS_SETUP0 + 6'h02, 8'(c << 3));
      chk({5'h0, keeper[2], pull_en[2], pull_en[2] & pull_up[2]}, {5'h0, c == 1, c[1], c[1] & c[0]});
    end
    wr(GPR_OFS_MPMASK, 8'h0C);
    wr(GPR_OFS_SETUP0 + 6'h04, 8'h19);
    rc(GPR_OFS_SETUP0 + 6'h02, 8'h19);
    rc(GPR_OFS_SETUP0 + 6'h03, 8'h19);
    rc(GPR_OFS_SETUP0 + 6'h04, 8'h00);
    rc(GPR_OFS_MPMASK, 8'h00);
    wr(GPR_OFS_SETUP0 + 6'h04, 8'h01);
    rc(GPR_OFS_SETUP0 + 6'h03, 8'h19);
    wr(GPR_OFS_IRQ0SEL, 8'h10);
    wr(GPR_OFS_IRQPRI, 8'h01);
    chk({4'h0, o_irq_level}, 8'h01);
    rc(GPR_OFS_PEND, 8'h00);
    ext_val[4] = 1'b1;
    for (int k = 0; k < 10 && o_irq_req[0] !== 1'b1; k++)
      cyc(1);
    if (o_irq_req[0] !== 1'b1) begin
      failures++;
      $display("FAIL t=%0t interrupt request wait ran out", $time);
      give_verdict();
    end
    rc(GPR_OFS_PEND, 8'h01);
    chk({6'h0, o_irq_req}, 8'h01);
    wr(GPR_OFS_PEND, 8'hFE);
    rc(GPR_OFS_PEND, 8'h01);
    wr(GPR_OFS_PEND, 8'hFF);
    rc(GPR_OFS_PEND, 8'h00);
    wr(GPR_OFS_SETUP0 + 6'h05, 8'h02);
    wr(GPR_OFS_IRQ1SEL, 8'h20);
    wr(GPR_OFS_IRQPRI, 8'h0C);
    chk({4'h0, o_irq_level}, 8'h0C);
    ext_val[5] = 1'b0;
    cyc(6);
    rc(GPR_OFS_PEND, 8'h02);
    chk({6'h0, o_irq_req}, 8'h02);
    bus(1'b1, 1'b1, 6'h03, 8'h02);
    rc(GPR_OFS_PEND, 8'h00);
    bus(1'b1, 1'b1, 6'h00, 8'h30);
    rc(GPR_OFS_DIR, 8'h30);
    bus(1'b1, 1'b0, 6'h09, 8'h00);
    chk(rd, 8'h04);
    bus(1'b1, 1'b0, 6'h04, 8'h00);
    chk(rd, 8'h00);
    ext_val[6] = 1'b1;
    wr(GPR_OFS_SETUP0 + 6'h06, 8'h03);
    cyc(4);
    for (int k = 0; k < 3; k++) begin
      chk({7'h0, o_pin_event[6]}, 8'h01);
      cyc(1);
    end
    wr(GPR_OFS_DIR_SET, 8'h80);
    i_evt_route = 1'b1;
    i_evt_ch0 = 1'b1;
    cyc(1);
    chk({7'h0, o_pad_out[7]}, 8'h01);
    i_evt_ch0 = 1'b0;
    cyc(1);
    chk({7'h0, o_pad_out[7]}, 8'h00);
    // clock route wins over a raised event: pin follows the clock phase
    i_evt_ch0 = 1'b1;
    i_clk_route = 1'b1;
    cyc(1);
    chk({7'h0, o_pad_out[7]}, 8'h01);
    #5;
    chk({7'h0, o_pad_out[7]}, 8'h00);
    give_verdict();
  end
endmodule
